// *** msio_pkg.sv ***
package msio_pkg;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned US_TIME = 1;
	localparam logic [3:0] US_CYCLES = 4'((US_TIME * CLK_HZ + 999_999) / 1_000_000);
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_IN_FLAGS = 8'h00;
	localparam logic [7:0] OFS_DEAD_TIME = 8'h04;
	localparam logic [7:0] OFS_TGT_STEPS = 8'h08;
	localparam logic [7:0] OFS_TGT_FRAC = 8'h0c;
	localparam logic [7:0] OFS_SPEED = 8'h10;
	localparam logic [7:0] OFS_SPEED_FRAC = 8'h14;
	localparam logic [7:0] OFS_OUT_FLAGS = 8'h18;
	localparam logic [7:0] OFS_PULSE_WIDTH = 8'h1c;
	localparam logic [7:0] OFS_PULSE_INTERVAL = 8'h20;
	localparam logic [7:0] OFS_TOL_STEPS = 8'h24;
	localparam logic [7:0] OFS_TOL_FRAC = 8'h28;
	localparam logic [7:0] OFS_STATUS = 8'h2c;
	localparam logic [7:0] OFS_QUEUE_FRAC = 8'h30;
	localparam logic [7:0] OFS_QUEUE_STEPS = 8'h34;
	// ----------------------------------------
	// fields and reset values
	// ----------------------------------------
	localparam int unsigned IN_FLAGS_W = 3;
	localparam int unsigned OUT_FLAGS_W = 7;
	localparam int unsigned QUEUE_DEPTH = 4;
	localparam int unsigned QPTR_W = 2;
	localparam logic [IN_FLAGS_W-1:0] IN_FLAGS_RST = 3'h0;
	localparam logic [OUT_FLAGS_W-1:0] OUT_FLAGS_RST = 7'h00;
	localparam logic [15:0] DEAD_TIME_RST = 16'h0000;
	localparam logic [15:0] PULSE_WIDTH_RST = 16'h0001;
	localparam logic [15:0] PULSE_INTERVAL_RST = 16'h0001;
	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic trigger_in_absolute_target;
		logic trigger_in_falling_edge;
		logic trigger_in_enable;
	} msio_in_flags_s;
	typedef struct packed {
		logic pulse_periodic_enable;
		logic pulse_on_motion_end;
		logic pulse_on_motion_begin;
		logic pulse_out_step_units;
		logic pulse_out_active_low;
		logic pulse_out_fixed_level;
		logic pulse_out_enable;
	} msio_out_flags_s;
	typedef struct packed {
		logic absolute;
		logic signed [31:0] steps;
		logic signed [15:0] target_fraction_microsteps;
		logic [31:0] speed;
		logic [7:0] target_speed_fraction;
	} msio_move_s;
	typedef struct packed {
		logic signed [31:0] steps;
		logic signed [15:0] frac;
	} msio_qent_s;
endpackage

// *** msio_motion_sync.sv ***
`timescale 1ns/1ps
module msio_motion_sync (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// sync pins
	input wire logic sync_in_pin,
	output logic sync_out_pin,
	// motion core
	input wire logic motion_active,
	input wire logic motion_step_tick,
	input wire logic motor_is_stepper,
	input wire logic [3:0] microstep_shift,
	input wire logic signed [31:0] pos_steps,
	input wire logic signed [15:0] pos_frac,
	output logic move_start,
	output msio_pkg::msio_move_s move_cmd
);
	import msio_pkg::*;

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	logic [1:0] rst_sync_q;
	logic rst_n_q;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n_q = rst_sync_q[1];
	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	msio_in_flags_s in_flags_q;
	msio_out_flags_s out_flags_q;
	logic [15:0] dead_q;
	logic signed [31:0] tgt_steps_q;
	logic signed [15:0] tgt_frac_q;
	logic [31:0] speed_q;
	logic [7:0] speed_frac_q;
	logic [15:0] width_q;
	logic [15:0] interval_q;
	logic [31:0] tol_q;
	logic [7:0] tol_frac_q;
	logic signed [15:0] qfrac_q;
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			in_flags_q <= IN_FLAGS_RST;
			out_flags_q <= OUT_FLAGS_RST;
			dead_q <= DEAD_TIME_RST;
			tgt_steps_q <= 32'h0;
			tgt_frac_q <= 16'h0;
			speed_q <= 32'h0;
			speed_frac_q <= 8'h0;
			width_q <= PULSE_WIDTH_RST;
			interval_q <= PULSE_INTERVAL_RST;
			tol_q <= 32'h0;
			tol_frac_q <= 8'h0;
			qfrac_q <= 16'h0;
		end else if (reg_wr) begin
			unique case (reg_addr)
				OFS_IN_FLAGS: in_flags_q <= reg_wdata[IN_FLAGS_W-1:0];
				OFS_DEAD_TIME: dead_q <= reg_wdata[15:0];
				OFS_TGT_STEPS: tgt_steps_q <= reg_wdata;
				OFS_TGT_FRAC: tgt_frac_q <= reg_wdata[15:0];
				OFS_SPEED: speed_q <= reg_wdata;
				OFS_SPEED_FRAC: speed_frac_q <= reg_wdata[7:0];
				OFS_OUT_FLAGS: out_flags_q <= reg_wdata[OUT_FLAGS_W-1:0];
				OFS_PULSE_WIDTH: width_q <= reg_wdata[15:0];
				OFS_PULSE_INTERVAL: interval_q <= reg_wdata[15:0];
				OFS_TOL_STEPS: tol_q <= reg_wdata;
				OFS_TOL_FRAC: tol_frac_q <= reg_wdata[7:0];
				OFS_QUEUE_FRAC: qfrac_q <= reg_wdata[15:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// input synchroniser and edge detect
	// ----------------------------------------
	logic [2:0] sin_q;
	logic sin_level_q;
	logic rise;
	logic fall;
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			sin_q <= 3'h0;
			sin_level_q <= 1'b0;
		end else begin
			sin_q <= {sin_q[1:0], sync_in_pin};
			if (sin_q[1] == sin_q[2]) begin
				sin_level_q <= sin_q[2];
			end
		end
	end
	assign rise = (sin_q[1] == sin_q[2]) && sin_q[2] && !sin_level_q;
	assign fall = (sin_q[1] == sin_q[2]) && !sin_q[2] && sin_level_q;

	// ----------------------------------------
	// trigger qualification and dead time
	// ----------------------------------------
	logic [15:0] dead_cnt_q;
	logic [3:0] dead_pre_q;
	logic dead_active;
	logic edge_sel;
	logic trig;
	assign dead_active = dead_cnt_q != 16'h0;
	assign edge_sel = in_flags_q.trigger_in_falling_edge ? fall : rise;
	assign trig = in_flags_q.trigger_in_enable && edge_sel && !dead_active;
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			dead_cnt_q <= 16'h0;
			dead_pre_q <= 4'h0;
		end else if (trig) begin
			dead_cnt_q <= dead_q;
			dead_pre_q <= US_CYCLES - 4'h1;
		end else if (dead_active) begin
			if (dead_pre_q == 4'h0) begin
				dead_pre_q <= US_CYCLES - 4'h1;
				dead_cnt_q <= dead_cnt_q - 16'h1;
			end else begin
				dead_pre_q <= dead_pre_q - 4'h1;
			end
		end
	end

	// ----------------------------------------
	// queued command buffer
	// ----------------------------------------
	msio_qent_s qmem [QUEUE_DEPTH];
	logic [QPTR_W-1:0] qwr_q;
	logic [QPTR_W-1:0] qrd_q;
	logic [QPTR_W:0] qcnt_q;
	logic qpush;
	logic qpop;
	assign qpush = reg_wr && (reg_addr == OFS_QUEUE_STEPS) && (qcnt_q != (QPTR_W+1)'(QUEUE_DEPTH));
	assign qpop = trig && (qcnt_q != '0);
	always_ff @(posedge clk_sys) begin
		if (qpush) begin
			qmem[qwr_q] <= {reg_wdata, qfrac_q};
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			qwr_q <= '0;
			qrd_q <= '0;
			qcnt_q <= '0;
		end else begin
			if (qpush) begin
				qwr_q <= qwr_q + QPTR_W'(1);
			end
			if (qpop) begin
				qrd_q <= qrd_q + QPTR_W'(1);
			end
			if (qpush && !qpop) begin
				qcnt_q <= qcnt_q + (QPTR_W+1)'(1);
			end else if (qpop && !qpush) begin
				qcnt_q <= qcnt_q - (QPTR_W+1)'(1);
			end
		end
	end

	// ----------------------------------------
	// move launch
	// ----------------------------------------
	function automatic logic signed [47:0] to_us(input logic signed [31:0] s,
			input logic signed [15:0] f, input logic [3:0] sh);
		to_us = ($signed({{16{s[31]}}, s}) <<< sh) + $signed({{32{f[15]}}, f});
	endfunction
	logic signed [31:0] launch_steps;
	logic signed [15:0] launch_frac;
	logic signed [47:0] pos_us;
	logic signed [47:0] tgt_us_q;
	assign launch_steps = qpop ? qmem[qrd_q].steps : tgt_steps_q;
	assign launch_frac = qpop ? qmem[qrd_q].frac : tgt_frac_q;
	assign pos_us = to_us(pos_steps, pos_frac, microstep_shift);
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			move_start <= 1'b0;
			move_cmd <= '0;
			tgt_us_q <= 48'h0;
		end else begin
			move_start <= trig;
			if (trig) begin
				move_cmd.absolute <= in_flags_q.trigger_in_absolute_target;
				move_cmd.steps <= launch_steps;
				move_cmd.target_fraction_microsteps <= launch_frac;
				move_cmd.speed <= speed_q;
				move_cmd.target_speed_fraction <= speed_frac_q;
				if (in_flags_q.trigger_in_absolute_target) begin
					tgt_us_q <= to_us(launch_steps, launch_frac, microstep_shift);
				end else begin
					tgt_us_q <= pos_us + to_us(launch_steps, launch_frac, microstep_shift);
				end
			end
		end
	end

	// ----------------------------------------
	// target neighbourhood
	// ----------------------------------------
	logic signed [47:0] diff;
	logic [47:0] abs_diff;
	logic [47:0] tol_us;
	logic in_tol;
	logic in_tol_q;
	logic motion_q;
	logic tracking_q;
	logic begin_evt;
	logic end_evt;
	assign diff = pos_us - tgt_us_q;
	assign abs_diff = diff[47] ? 48'(-diff) : 48'(diff);
	assign tol_us = ({16'h0, tol_q} << microstep_shift)
		+ (motor_is_stepper ? {40'h0, tol_frac_q} : 48'h0);
	assign in_tol = abs_diff <= tol_us;
	assign begin_evt = motion_active && !motion_q;
	assign end_evt = tracking_q && ((!motion_active && motion_q) || (in_tol && !in_tol_q));
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			in_tol_q <= 1'b0;
			motion_q <= 1'b0;
			tracking_q <= 1'b0;
		end else begin
			in_tol_q <= in_tol;
			motion_q <= motion_active;
			if (begin_evt) begin
				tracking_q <= 1'b1;
			end else if (end_evt) begin
				tracking_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// periodic counter
	// ----------------------------------------
	logic [15:0] per_cnt_q;
	logic period_evt;
	assign period_evt = out_flags_q.pulse_periodic_enable && motion_step_tick
		&& (per_cnt_q + 16'h1 >= interval_q);
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			per_cnt_q <= 16'h0;
		end else if (!out_flags_q.pulse_periodic_enable || period_evt) begin
			per_cnt_q <= 16'h0;
		end else if (motion_step_tick) begin
			per_cnt_q <= per_cnt_q + 16'h1;
		end
	end

	// ----------------------------------------
	// pulse generator
	// ----------------------------------------
	logic pulse_req;
	logic pulse_q;
	logic [15:0] pw_cnt_q;
	logic [3:0] pw_pre_q;
	logic pw_tick;
	assign pulse_req = (out_flags_q.pulse_on_motion_begin && begin_evt)
		|| (out_flags_q.pulse_on_motion_end && end_evt) || period_evt;
	assign pw_tick = out_flags_q.pulse_out_step_units ? motion_step_tick : (pw_pre_q == 4'h0);
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pulse_q <= 1'b0;
			pw_cnt_q <= 16'h0;
			pw_pre_q <= 4'h0;
		end else if (pulse_req) begin
			pulse_q <= 1'b1;
			pw_cnt_q <= width_q;
			pw_pre_q <= US_CYCLES - 4'h1;
		end else if (pulse_q) begin
			pw_pre_q <= (pw_pre_q == 4'h0) ? US_CYCLES - 4'h1 : pw_pre_q - 4'h1;
			if (pw_tick) begin
				if (pw_cnt_q <= 16'h1) begin
					pulse_q <= 1'b0;
				end
				pw_cnt_q <= pw_cnt_q - 16'h1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			sync_out_pin <= 1'b0;
		end else if (out_flags_q.pulse_out_enable) begin
			sync_out_pin <= pulse_q ^ out_flags_q.pulse_out_active_low;
		end else begin
			sync_out_pin <= out_flags_q.pulse_out_fixed_level;
		end
	end

	// ----------------------------------------
	// register read
	// ----------------------------------------
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0;
		unique case (reg_addr)
			OFS_IN_FLAGS: rd_mux = {29'h0, in_flags_q};
			OFS_DEAD_TIME: rd_mux = {16'h0, dead_q};
			OFS_TGT_STEPS: rd_mux = tgt_steps_q;
			OFS_TGT_FRAC: rd_mux = {16'h0, tgt_frac_q};
			OFS_SPEED: rd_mux = speed_q;
			OFS_SPEED_FRAC: rd_mux = {24'h0, speed_frac_q};
			OFS_OUT_FLAGS: rd_mux = {25'h0, out_flags_q};
			OFS_PULSE_WIDTH: rd_mux = {16'h0, width_q};
			OFS_PULSE_INTERVAL: rd_mux = {16'h0, interval_q};
			OFS_TOL_STEPS: rd_mux = tol_q;
			OFS_TOL_FRAC: rd_mux = {24'h0, tol_frac_q};
			OFS_STATUS: rd_mux = {24'h0, qcnt_q, in_tol_q, pulse_q, dead_active, sin_level_q, tracking_q};
			OFS_QUEUE_FRAC: rd_mux = {16'h0, qfrac_q};
			default: rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			reg_rdata <= 32'h0;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : 32'h0;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_disabled_no_launch: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
		!in_flags_q.trigger_in_enable |=> !move_start)
		else $error("launch while input trigger disabled");
	chk_dead_blocks_launch: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
		dead_active |=> !move_start)
		else $error("launch during dead time");
	chk_edge_launches: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
		(in_flags_q.trigger_in_enable && !dead_active && !in_flags_q.trigger_in_falling_edge && rise)
		|=> move_start ##1 !move_start)
		else $error("rising edge did not launch one move");
	chk_abs_select: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
		move_start |-> move_cmd.absolute == $past(in_flags_q.trigger_in_absolute_target))
		else $error("absolute flag not applied to move");
	chk_fixed_level: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
		!out_flags_q.pulse_out_enable ##1 !out_flags_q.pulse_out_enable
		|-> sync_out_pin == $past(out_flags_q.pulse_out_fixed_level))
		else $error("output not at fixed level");
	chk_out_polarity: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
		out_flags_q.pulse_out_enable |=> sync_out_pin == ($past(pulse_q) ^ $past(out_flags_q.pulse_out_active_low)))
		else $error("output polarity wrong");
	chk_begin_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
		(out_flags_q.pulse_on_motion_begin && begin_evt) |=> pulse_q)
		else $error("no pulse at motion begin");
	chk_queue_pop: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
		(qpop && !qpush) |=> qcnt_q == $past(qcnt_q) - 3'h1 && move_cmd.steps == $past(qmem[qrd_q].steps))
		else $error("queued command not launched and removed");
endmodule

// *** msio_motion_model.sv ***
`timescale 1ns/1ps
module msio_motion_model #(
	parameter int TICK_GAP = 8
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// bench control
	input wire logic run,
	input wire logic ticking,
	// motion status
	output logic motion_active,
	output logic motion_step_tick,
	output logic signed [31:0] pos_steps,
	output logic signed [15:0] pos_frac
);
	int gap_q;
	// ----------------------------------------
	// motion level and step ticks
	// ----------------------------------------
	// ticks come only while moving, as a real motor core would give them
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			motion_active <= 1'b0;
			motion_step_tick <= 1'b0;
			gap_q <= 0;
			pos_steps <= 32'sh0;
		end else begin
			motion_active <= run;
			motion_step_tick <= 1'b0;
			if (run && ticking) begin
				gap_q <= (gap_q == TICK_GAP - 1) ? 0 : gap_q + 1;
				if (gap_q == TICK_GAP - 1) begin
					motion_step_tick <= 1'b1;
					pos_steps <= pos_steps + 32'sh1;
				end
			end
		end
	end
	assign pos_frac = 16'sh0;
endmodule

// *** msio_motion_sync_test.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
	$display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module msio_motion_sync_test;
	import msio_pkg::*;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic sync_in_pin = 1'b0;
	logic sync_out_pin;
	logic run = 1'b0;
	logic ticking = 1'b0;
	logic motor_is_stepper = 1'b1;
	logic [3:0] microstep_shift = 4'h0;
	logic motion_active, motion_step_tick, move_start;
	logic signed [31:0] pos_steps;
	logic signed [15:0] pos_frac;
	msio_move_s move_cmd;
	int miscompares = 0;
	int comparisons = 0;
	int launches = 0;
	int n;
	logic [31:0] d;

	always #50 clk_sys = ~clk_sys;

	msio_motion_sync dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sync_in_pin(sync_in_pin),
		.sync_out_pin(sync_out_pin), .motion_active(motion_active), .motion_step_tick(motion_step_tick),
		.motor_is_stepper(motor_is_stepper), .microstep_shift(microstep_shift), .pos_steps(pos_steps),
		.pos_frac(pos_frac), .move_start(move_start), .move_cmd(move_cmd));

	msio_motion_model motion_u (.clk_sys(clk_sys), .reset_n(reset_n), .run(run), .ticking(ticking),
		.motion_active(motion_active), .motion_step_tick(motion_step_tick), .pos_steps(pos_steps),
		.pos_frac(pos_frac));

	always @(negedge clk_sys) begin
		if (move_start === 1'b1) begin
			launches++;
		end
	end

	// ----------------------------------------
	// access tasks
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		v = reg_rdata;
	endtask

	task automatic pin(input logic v, input int hold);
		@(posedge clk_sys);
		sync_in_pin <= v;
		repeat (hold) @(posedge clk_sys);
	endtask

	task automatic motion(input logic r, input logic t);
		@(posedge clk_sys);
		run <= r;
		ticking <= t;
	endtask

	// cycles that the pin stays at the given level, once it gets there
	task automatic width(input logic act, output int cnt);
		int i;
		cnt = 0;
		for (i = 0; i < 40 && sync_out_pin !== act; i++) @(negedge clk_sys);
		while (sync_out_pin === act && cnt < 300) begin
			cnt++;
			@(negedge clk_sys);
		end
	endtask

	// step ticks from one pulse rise to the next
	task automatic gap_ticks(output int t);
		int i;
		t = 0;
		for (i = 0; i < 200 && sync_out_pin !== 1'b1; i++) @(negedge clk_sys);
		for (i = 0; i < 200 && sync_out_pin !== 1'b0; i++) begin
			if (motion_step_tick === 1'b1) begin
				t++;
			end
			@(negedge clk_sys);
		end
		for (i = 0; i < 400 && sync_out_pin !== 1'b1; i++) begin
			if (motion_step_tick === 1'b1) begin
				t++;
			end
			@(negedge clk_sys);
		end
	endtask

	task automatic print_verdict();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		#2_000_000;
		miscompares++;
		print_verdict();
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (16) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		rd(OFS_IN_FLAGS, d); `CHK(d, 32'h0)
		rd(OFS_OUT_FLAGS, d); `CHK(d, 32'h0)
		rd(OFS_PULSE_WIDTH, d); `CHK(d, 32'h1)
		rd(OFS_PULSE_INTERVAL, d); `CHK(d, 32'h1)
		rd(8'h3c, d); `CHK(d, 32'h0)
		wr(OFS_DEAD_TIME, 32'hffff);
		rd(OFS_DEAD_TIME, d); `CHK(d, 32'hffff)
		// fixed level while the pulse logic is off
		wr(OFS_OUT_FLAGS, 32'h02);
		repeat (3) @(negedge clk_sys);
		`CHK(sync_out_pin, 1'b1)
		wr(OFS_OUT_FLAGS, 32'h00);
		repeat (3) @(negedge clk_sys);
		`CHK(sync_out_pin, 1'b0)
		// triggered moves
		wr(OFS_DEAD_TIME, 32'h0);
		wr(OFS_TGT_STEPS, 32'hfffe7960);
		wr(OFS_TGT_FRAC, 32'h0000fffd);
		wr(OFS_SPEED, 32'h000186a0);
		wr(OFS_SPEED_FRAC, 32'h7f);
		pin(1'b1, 8);
		pin(1'b0, 8);
		`CHK(launches, 0)
		wr(OFS_IN_FLAGS, 32'h5);
		pin(1'b1, 8);
		`CHK(launches, 1)
		`CHK(move_cmd.absolute, 1'b1)
		`CHK(move_cmd.steps, 32'shfffe7960)
		`CHK(move_cmd.target_fraction_microsteps, 16'shfffd)
		`CHK(move_cmd.speed, 32'h000186a0)
		`CHK(move_cmd.target_speed_fraction, 8'h7f)
		pin(1'b0, 8);
		`CHK(launches, 1)
		wr(OFS_IN_FLAGS, 32'h3);
		pin(1'b1, 8);
		pin(1'b0, 8);
		`CHK(launches, 2)
		`CHK(move_cmd.absolute, 1'b0)
		// dead time of 2 us swallows a quick second edge
		wr(OFS_DEAD_TIME, 32'h2);
		wr(OFS_IN_FLAGS, 32'h1);
		pin(1'b1, 5);
		pin(1'b0, 5);
		pin(1'b1, 8);
		`CHK(launches, 3)
		pin(1'b0, 30);
		pin(1'b1, 8);
		`CHK(launches, 4)
		// queued entry goes first, then the configured target again
		wr(OFS_DEAD_TIME, 32'h0);
		wr(OFS_QUEUE_FRAC, 32'h7);
		wr(OFS_QUEUE_STEPS, 32'h12345678);
		rd(OFS_STATUS, d); `CHK(d[7:5], 3'h1)
		pin(1'b0, 8);
		pin(1'b1, 8);
		`CHK(move_cmd.steps, 32'sh12345678)
		`CHK(move_cmd.target_fraction_microsteps, 16'sh0007)
		rd(OFS_STATUS, d); `CHK(d[7:5], 3'h0)
		pin(1'b0, 8);
		pin(1'b1, 8);
		`CHK(move_cmd.steps, 32'shfffe7960)
		// output pulses
		wr(OFS_PULSE_WIDTH, 32'h3);
		wr(OFS_OUT_FLAGS, 32'h11);
		motion(1'b1, 1'b0);
		width(1'b1, n); `CHK(n >= 20 && n <= 31, 1'b1)
		motion(1'b0, 1'b0);
		wr(OFS_OUT_FLAGS, 32'h15);
		repeat (3) @(negedge clk_sys);
		`CHK(sync_out_pin, 1'b1)
		motion(1'b1, 1'b0);
		width(1'b0, n); `CHK(n >= 20 && n <= 31, 1'b1)
		motion(1'b0, 1'b0);
		wr(OFS_PULSE_WIDTH, 32'h2);
		wr(OFS_OUT_FLAGS, 32'h19);
		motion(1'b1, 1'b0);
		repeat (60) @(negedge clk_sys);
		`CHK(sync_out_pin, 1'b1)
		motion(1'b1, 1'b1);
		repeat (30) @(negedge clk_sys);
		`CHK(sync_out_pin, 1'b0)
		wr(OFS_PULSE_WIDTH, 32'h1);
		wr(OFS_OUT_FLAGS, 32'h21);
		motion(1'b0, 1'b0);
		width(1'b1, n); `CHK(n >= 5 && n <= 11, 1'b1)
		wr(OFS_PULSE_INTERVAL, 32'h3);
		wr(OFS_OUT_FLAGS, 32'h41);
		motion(1'b1, 1'b1);
		gap_ticks(n); `CHK(n, 3)
		motion(1'b0, 1'b0);
		// stop pulse on entering the tolerance band of a relative move
		wr(OFS_TOL_STEPS, 32'h1);
		wr(OFS_TOL_FRAC, 32'h1);
		wr(OFS_TGT_STEPS, 32'h5);
		wr(OFS_TGT_FRAC, 32'h0);
		wr(OFS_OUT_FLAGS, 32'h21);
		pin(1'b0, 8);
		pin(1'b1, 8);
		d = pos_steps;
		motion(1'b1, 1'b1);
		for (n = 0; n < 200 && sync_out_pin !== 1'b1; n++) @(negedge clk_sys);
		`CHK(pos_steps - d, 32'h3)
		motion(1'b0, 1'b0);
		print_verdict();
	end
endmodule
